// ==== shared/csw_map.vh ====
// Overview of operation
// - Bit 7 enables an area's settings
// - Reset: only area 2 enabled
// - Bit 3 picks width, 1 = 8-bit
// - Width follows area of each access
// - 8-bit area: bytes ascending on low lane
// - 16-bit area: odd byte upper, then halfwords
// - Unused read lanes are ignored
// - Unused write lanes float, strobe idle
// - Bits 2..0 select wait policy
// - Code 000 gives two fixed waits
// - Code 001 gives one fixed wait
// - Code 010: one wait, then pin-extended
// - Code 011 gives no wait
// - Codes 101/110/111 give 3/4/8 waits
// - Reset wait field is 000
// - Default register covers unmatched addresses
// - Area 2 select bit, reset 0
// - Internal addresses assert no chip select
`ifndef CSW_MAP_VH
`define CSW_MAP_VH
`define CSW_IDX_AREA0 8'hc0
`define CSW_IDX_AREA1 8'hc1
`define CSW_IDX_AREA2 8'hc2
`define CSW_IDX_AREA3 8'hc3
`define CSW_IDX_DEF 8'hc7
`define CSW_IDX_STAT 8'hc8
`define CSW_BIT_EN 7
`define CSW_BIT_REGION 6
`define CSW_BIT_BUS 3
`define CSW_RST_AREA 8'h00
`define CSW_RST_AREA2 8'h80
`define CSW_RST_DEF 4'h0
`define CSW_WC_2 3'h0
`define CSW_WC_1 3'h1
`define CSW_WC_1N 3'h2
`define CSW_WC_0 3'h3
`define CSW_WC_RSV 3'h4
`define CSW_WC_3 3'h5
`define CSW_WC_4 3'h6
`define CSW_WC_8 3'h7
`define CSW_WN_2 4'h2
`define CSW_WN_1 4'h1
`define CSW_WN_0 4'h0
`define CSW_WN_3 4'h3
`define CSW_WN_4 4'h4
`define CSW_WN_8 4'h8
`endif

// ==== testbench/chip_select_wait_bus_sizing_tb_top.sv ====
`default_nettype none
module chip_select_wait_bus_sizing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_req_i;
  logic cpu_we_i, internal_hit_i, cpu_ack_o, ext_rd_n_o, ext_wrl_n_o;
  logic ext_wrh_n_o, ext_wait_n_i, w8, slow, wsel;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i, area_hit_i, ext_cs_n_o, cs_seen;
  logic [31:0] wb_dat_i, wb_dat_o, cpu_wdata_i, cpu_rdata_o, rdat, crd, v, m;
  logic [1:0] cpu_size_i, ext_d_oe_o, sz;
  logic [23:0] cpu_addr_i, ext_addr_o, a;
  logic [15:0] ext_d_i, ext_d_o;
  logic [2:0] c;
  int n_fail, cmp_count, cur, slen, nfall, f0, i;
  csw_ctrl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_we_i,
    .cpu_size_i, .cpu_addr_i, .cpu_wdata_i, .area_hit_i, .internal_hit_i,
    .cpu_ack_o, .cpu_rdata_o, .ext_addr_o, .ext_cs_n_o, .ext_rd_n_o,
    .ext_wrl_n_o, .ext_wrh_n_o, .ext_d_i, .ext_d_o, .ext_d_oe_o,
    .ext_wait_n_i);
  csw_mem_model mem_i (.clk_i, .w8_i(w8), .slow_i(slow), .addr_i(ext_addr_o),
    .rd_n_i(ext_rd_n_o), .wrl_n_i(ext_wrl_n_o), .wrh_n_i(ext_wrh_n_o),
    .d_i(ext_d_o), .d_o(ext_d_i), .wait_n_o(ext_wait_n_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic await(input bit cpu);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(cpu ? cpu_ack_o : wb_ack_o) && n < 400);
    if (n >= 400) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    await(0);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic op(input logic we, input logic [1:0] s, input logic [23:0] ad,
                    input logic [31:0] d);
    @(posedge clk_i);
    cpu_req_i <= 1'b1;
    cpu_we_i <= we;
    cpu_size_i <= s;
    cpu_addr_i <= ad;
    cpu_wdata_i <= d;
    f0 = nfall;
    await(1);
    crd = cpu_rdata_o;
    cpu_req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic int wlen(input logic [2:0] code);
    case (code)
      3'h0: return 3;
      3'h1, 3'h2: return 2;
      3'h3: return 1;
      3'h5: return 4;
      3'h6: return 5;
      default: return 9;
    endcase
  endfunction
  function automatic int ncyc(input logic w, input logic [1:0] s,
                              input logic [23:0] ad);
    int r, n;
    r = s == 0 ? 1 : s == 1 ? 2 : 4;
    n = 0;
    while (r > 0) begin
      r -= (w || ad[0] || r == 1) ? 1 : 2;
      ad += (w || ad[0] || r == 0) ? 1 : 2;
      n++;
    end
    return n;
  endfunction
  // Strobe-low run length and bus-cycle count seen on the pins
  always @(posedge clk_i) begin
    if (!(ext_rd_n_o && ext_wrl_n_o && ext_wrh_n_o)) begin
      if (cur == 0) nfall <= nfall + 1;
      cur <= cur + 1;
      cs_seen <= ext_cs_n_o;
    end else if (cur != 0) begin
      slen <= cur;
      cur <= 0;
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_sel_i} = 5'h11;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {cpu_req_i, cpu_we_i, cpu_size_i, cpu_addr_i, cpu_wdata_i} = '0;
    {area_hit_i, internal_hit_i, w8, slow} = '0;
    {n_fail, cmp_count} = '0;
    void'($urandom(37));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 6; i++) begin
      wb(1'b0, i == 5 ? 8'hc7 : 8'(8'hc0 + i), 8'h00);
      check(rdat, i == 2 ? 32'h80 : 32'h0);
    end
    // Idle status: not busy, filtered wait level high
    wb(1'b0, 8'hc8, 8'h00);
    check(rdat, 32'h2);
    op(1'b0, 2'd0, 24'h10, 32'h0);
    check({cs_seen, 28'(slen)}, {4'hb, 28'd3});
    for (i = 0; i < 9; i++) if (i != 4) begin
      c = i == 8 ? 3'h2 : 3'(i);
      slow <= i == 2 ? 1'b1 : i == 8 ? 1'b0 : 1'($urandom % 2);
      w8 <= 1'b1;
      wb(1'b1, 8'hc2, {5'h11, c});
      op(1'b1, 2'd0, 24'($urandom % 256), $urandom);
      if (c == 3'h2 && slow) check(slen > 2, 1);
      else check(slen, wlen(c));
    end
    area_hit_i <= 4'h1;
    wb(1'b1, 8'hc0, 8'h0b);
    op(1'b0, 2'd0, 24'h21, 32'h0);
    check(cs_seen, 4'hb);
    wb(1'b1, 8'hc0, 8'h8b);
    op(1'b0, 2'd0, 24'h21, 32'h0);
    check({cs_seen, 28'(slen)}, {4'he, 28'd1});
    // Area 2 limited to its decoded region: a miss falls to default
    area_hit_i <= 4'h4;
    wb(1'b1, 8'hc2, 8'hcb);
    op(1'b0, 2'd0, 24'h21, 32'h0);
    check({cs_seen, 28'(slen)}, {4'hb, 28'd1});
    area_hit_i <= 4'h0;
    op(1'b0, 2'd0, 24'h21, 32'h0);
    check({cs_seen, 28'(slen)}, {4'hf, 28'd3});
    wb(1'b1, 8'hc2, 8'h00);
    wb(1'b1, 8'hc7, 8'h0d);
    op(1'b0, 2'd0, 24'h30, 32'h0);
    check({cs_seen, 28'(slen)}, {4'hf, 28'd4});
    internal_hit_i <= 1'b1;
    op(1'b0, 2'd2, 24'h40, 32'h0);
    check(nfall - f0, 0);
    internal_hit_i <= 1'b0;
    for (i = 0; i < 14; i++) begin
      wsel = i == 0 ? 1'b0 : 1'($urandom % 2);
      sz = i == 0 ? 2'd2 : 2'($urandom % 4);
      a = i == 0 ? 24'h11 : 24'($urandom % 250);
      v = $urandom;
      m = sz == 0 ? 32'hff : sz == 1 ? 32'hffff : 32'hffffffff;
      w8 <= wsel;
      wb(1'b1, 8'hc2, {4'h8, wsel, 3'h3});
      op(1'b1, sz, a, v);
      check(nfall - f0, ncyc(wsel, sz, a));
      op(1'b0, sz, a, 32'h0);
      check(crd & m, v & m);
    end
    final_report();
  end
endmodule // chip_select_wait_bus_sizing_tb_top
`default_nettype wire

// ==== testbench/csw_ctrl_assertions.sv ====
`default_nettype none
module csw_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic cpu_ack_o,
  input wire logic [23:0] ext_addr_o,
  input wire logic [3:0] ext_cs_n_o,
  input wire logic ext_rd_n_o,
  input wire logic ext_wrl_n_o,
  input wire logic ext_wrh_n_o,
  input wire logic [1:0] ext_d_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Any strobe low marks the access phase of a bus cycle
  sequence s_strb;
    !ext_rd_n_o || !ext_wrl_n_o || !ext_wrh_n_o;
  endsequence
  sequence s_idle;
    ext_rd_n_o && ext_wrl_n_o && ext_wrh_n_o;
  endsequence
  chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wb ack held too long");
  chk_cpu_ack_gap: assert property (cpu_ack_o |=> s_idle[*2])
    else $error("strobes low right after cpu ack");
  chk_write_lanes: assert property (
    (!ext_wrl_n_o || !ext_wrh_n_o) |->
    ext_d_oe_o == {!ext_wrh_n_o, !ext_wrl_n_o})
    else $error("lane drive differs from write strobes");
  chk_read_float: assert property (
    !ext_rd_n_o |-> ext_d_oe_o == 2'b00 && ext_wrl_n_o && ext_wrh_n_o)
    else $error("bus driven during read");
  chk_high_odd: assert property (
    (!ext_wrh_n_o && ext_wrl_n_o) |-> ext_addr_o[0])
    else $error("upper lane alone at even address");
  chk_pair_even: assert property (
    (!ext_wrh_n_o && !ext_wrl_n_o) |-> !ext_addr_o[0])
    else $error("halfword at odd address");
  chk_addr_held: assert property (
    s_strb ##1 s_strb |-> $stable(ext_addr_o) && $stable(ext_cs_n_o))
    else $error("address moved within access");
  chk_one_area: assert property (s_strb |-> $onehot0(~ext_cs_n_o))
    else $error("several chip selects low");
endmodule // csw_ctrl_chk
bind csw_ctrl csw_ctrl_chk chk_i (.clk_i, .rst_i, .wb_ack_o, .cpu_ack_o,
  .ext_addr_o, .ext_cs_n_o, .ext_rd_n_o, .ext_wrl_n_o, .ext_wrh_n_o,
  .ext_d_oe_o);
`default_nettype wire

// ==== testbench/csw_mem_model.sv ====
`default_nettype none
module csw_mem_model (
  input wire logic clk_i,
  input wire logic w8_i,
  input wire logic slow_i,
  input wire logic [23:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wrl_n_i,
  input wire logic wrh_n_i,
  input wire logic [15:0] d_i,
  output logic [15:0] d_o,
  output logic wait_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [15:0] junk = 16'h5a3c;
  logic [3:0] cnt = 4'h0;
  logic [7:0] lo, hi;
  assign lo = w8_i ? addr_i[7:0] : {addr_i[7:1], 1'b0};
  assign hi = {addr_i[7:1], 1'b1};
  // Released lanes toggle so a stale byte can never pass as data
  assign d_o = rd_n_i ? junk : {w8_i ? junk[15:8] : mem[hi], mem[lo]};
  // Slow device holds the pin low from before the strobe on
  assign wait_n_o = !(slow_i && cnt < 4'h8);
  initial for (int k = 0; k < 256; k++) mem[k] = 8'(k * 7);
  always @(posedge clk_i) begin
    junk <= ~junk;
    if (rd_n_i && wrl_n_i && wrh_n_i) cnt <= 4'h0;
    else if (cnt != 4'h8) cnt <= cnt + 4'h1;
    if (!wrl_n_i) mem[lo] <= d_i[7:0];
    if (!wrh_n_i) mem[hi] <= d_i[15:8];
  end
endmodule // csw_mem_model
`default_nettype wire

// ==== verilog/csw_ctrl.v ====
`default_nettype none
module csw_ctrl (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cpu_req_i,
  input wire cpu_we_i,
  input wire [1:0] cpu_size_i,
  input wire [23:0] cpu_addr_i,
  input wire [31:0] cpu_wdata_i,
  input wire [3:0] area_hit_i,
  input wire internal_hit_i,
  output reg cpu_ack_o,
  output reg [31:0] cpu_rdata_o,
  output reg [23:0] ext_addr_o,
  output reg [3:0] ext_cs_n_o,
  output reg ext_rd_n_o,
  output reg ext_wrl_n_o,
  output reg ext_wrh_n_o,
  input wire [15:0] ext_d_i,
  output reg [15:0] ext_d_o,
  output reg [1:0] ext_d_oe_o,
  input wire ext_wait_n_i
);
`include "csw_map.vh"

localparam ST_IDLE = 2'd0;
localparam ST_SETUP = 2'd1;
localparam ST_STRB = 2'd2;
localparam ST_GAP = 2'd3;

////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] area_ctrl0;
reg [7:0] area_ctrl1;
reg [7:0] area_ctrl2;
reg [7:0] area_ctrl3;
reg [3:0] default_area_width_wait_ctrl;
reg [1:0] state;
reg [1:0] next_state;
reg wait_s1;
reg wait_s2;
reg wait_s3;
reg wait_lvl;

wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
// Write lands on the edge at which the master sees ack
wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
wire [7:0] wb_idx = wb_adr_i[9:2];

always @(posedge clk_i) begin
  if (rst_i) begin
    area_ctrl0 <= `CSW_RST_AREA;
    area_ctrl1 <= `CSW_RST_AREA;
    area_ctrl2 <= `CSW_RST_AREA2;
    area_ctrl3 <= `CSW_RST_AREA;
    default_area_width_wait_ctrl <= `CSW_RST_DEF;
  end else if (wb_wr) begin
    case (wb_idx)
      `CSW_IDX_AREA0: area_ctrl0 <= wb_dat_i[7:0];
      `CSW_IDX_AREA1: area_ctrl1 <= wb_dat_i[7:0];
      `CSW_IDX_AREA2: area_ctrl2 <= wb_dat_i[7:0];
      `CSW_IDX_AREA3: area_ctrl3 <= wb_dat_i[7:0];
      `CSW_IDX_DEF: default_area_width_wait_ctrl <= wb_dat_i[3:0];
      default: ;
    endcase
  end
end

always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else begin
    wb_ack_o <= wb_req;
    if (wb_req) begin
      case (wb_idx)
        `CSW_IDX_AREA0: wb_dat_o <= {24'h000000, area_ctrl0};
        `CSW_IDX_AREA1: wb_dat_o <= {24'h000000, area_ctrl1};
        `CSW_IDX_AREA2: wb_dat_o <= {24'h000000, area_ctrl2};
        `CSW_IDX_AREA3: wb_dat_o <= {24'h000000, area_ctrl3};
        `CSW_IDX_DEF:
          wb_dat_o <= {28'h0000000, default_area_width_wait_ctrl};
        `CSW_IDX_STAT:
          wb_dat_o <= {30'h0, wait_lvl, state != ST_IDLE};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Wait pin: three stages, level taken when the last two agree

always @(posedge clk_i) begin
  if (rst_i) begin
    wait_s1 <= 1'b1;
    wait_s2 <= 1'b1;
    wait_s3 <= 1'b1;
    wait_lvl <= 1'b1;
  end else begin
    wait_s1 <= ext_wait_n_i;
    wait_s2 <= wait_s1;
    wait_s3 <= wait_s2;
    if (wait_s2 == wait_s3)
      wait_lvl <= wait_s3;
  end
end

////////////////////////////////////////////////////////////////////////
// Area selection

// Returns {hit, area}; lowest numbered enabled area wins
function [2:0] csw_pick;
  input [3:0] hit;
  input [3:0] en;
  reg [3:0] m;
  begin
    m = hit & en;
    if (m[0])
      csw_pick = 3'h4;
    else if (m[1])
      csw_pick = 3'h5;
    else if (m[2])
      csw_pick = 3'h6;
    else if (m[3])
      csw_pick = 3'h7;
    else
      csw_pick = 3'h0;
  end
endfunction

wire [3:0] area_en = {area_ctrl3[`CSW_BIT_EN], area_ctrl2[`CSW_BIT_EN],
                      area_ctrl1[`CSW_BIT_EN], area_ctrl0[`CSW_BIT_EN]};
// Region 0 of area 2 claims all of the external space
wire area2_hit = area_ctrl2[`CSW_BIT_REGION] ? area_hit_i[2] : 1'b1;
wire [3:0] hits = {area_hit_i[3], area2_hit, area_hit_i[1:0]};
wire [2:0] pick = csw_pick(hits, area_en);
reg [7:0] pick_ctrl;

always @* begin
  case (pick[1:0])
    2'h0: pick_ctrl = area_ctrl0;
    2'h1: pick_ctrl = area_ctrl1;
    2'h2: pick_ctrl = area_ctrl2;
    default: pick_ctrl = area_ctrl3;
  endcase
  if (!pick[2])
    pick_ctrl = {4'h0, default_area_width_wait_ctrl};
end

////////////////////////////////////////////////////////////////////////
// Operand sequencer

reg lat_we;
reg lat_w8;
reg [2:0] lat_code;
reg [3:0] lat_cs_n;
reg [31:0] lat_wdata;
reg [23:0] cur_addr;
reg [2:0] rem;
reg [1:0] idx;
reg [1:0] cyc_n;
reg lo_use;
reg hi_use;
reg [1:0] lo_idx;
reg [1:0] hi_idx;
reg [1:0] s_n;
reg s_lo;
reg s_hi;
reg [1:0] s_lo_idx;
reg [1:0] s_hi_idx;
wire wdone;
wire start = (state == ST_SETUP);

// Byte split of the next bus cycle from address, width and bytes left
always @* begin
  s_lo_idx = idx;
  s_hi_idx = idx;
  if (lat_w8) begin
    s_n = 2'h1;
    s_lo = 1'b1;
    s_hi = 1'b0;
  end else if (cur_addr[0]) begin
    s_n = 2'h1;
    s_lo = 1'b0;
    s_hi = 1'b1;
  end else if (rem >= 3'h2) begin
    s_n = 2'h2;
    s_lo = 1'b1;
    s_hi = 1'b1;
    s_hi_idx = idx + 2'h1;
  end else begin
    s_n = 2'h1;
    s_lo = 1'b1;
    s_hi = 1'b0;
  end
end

always @* begin
  next_state = state;
  case (state)
    ST_IDLE:
      if (cpu_req_i)
        next_state = internal_hit_i ? ST_GAP : ST_SETUP;
    ST_SETUP: next_state = ST_STRB;
    ST_STRB:
      if (wdone)
        next_state = (rem == {1'b0, cyc_n}) ? ST_GAP : ST_SETUP;
    ST_GAP: next_state = ST_IDLE;
    default: next_state = ST_IDLE;
  endcase
end

always @(posedge clk_i) begin
  if (rst_i) begin
    state <= ST_IDLE;
    lat_we <= 1'b0;
    lat_w8 <= 1'b0;
    lat_code <= 3'h0;
    lat_cs_n <= 4'hf;
    lat_wdata <= 32'h00000000;
    cur_addr <= 24'h000000;
    rem <= 3'h0;
    idx <= 2'h0;
    cyc_n <= 2'h0;
    lo_use <= 1'b0;
    hi_use <= 1'b0;
    lo_idx <= 2'h0;
    hi_idx <= 2'h0;
    cpu_ack_o <= 1'b0;
    ext_addr_o <= 24'h000000;
    ext_cs_n_o <= 4'hf;
    ext_rd_n_o <= 1'b1;
    ext_wrl_n_o <= 1'b1;
    ext_wrh_n_o <= 1'b1;
    ext_d_o <= 16'h0000;
    ext_d_oe_o <= 2'h0;
  end else begin
    state <= next_state;
    cpu_ack_o <= 1'b0;
    case (state)
      ST_IDLE:
        if (cpu_req_i) begin
          // Internal targets get no external cycle at all
          if (internal_hit_i)
            cpu_ack_o <= 1'b1;
          lat_we <= cpu_we_i;
          lat_w8 <= pick_ctrl[`CSW_BIT_BUS];
          lat_code <= pick_ctrl[2:0];
          lat_cs_n <= pick[2] ? ~(4'h1 << pick[1:0]) : 4'hf;
          lat_wdata <= cpu_wdata_i;
          cur_addr <= cpu_addr_i;
          idx <= 2'h0;
          case (cpu_size_i)
            2'h0: rem <= 3'h1;
            2'h1: rem <= 3'h2;
            default: rem <= 3'h4;
          endcase
        end
      ST_SETUP: begin
        cyc_n <= s_n;
        lo_use <= s_lo;
        hi_use <= s_hi;
        lo_idx <= s_lo_idx;
        hi_idx <= s_hi_idx;
        ext_addr_o <= cur_addr;
        ext_cs_n_o <= lat_cs_n;
        ext_rd_n_o <= lat_we;
        ext_wrl_n_o <= !(lat_we && s_lo);
        ext_wrh_n_o <= !(lat_we && s_hi);
        ext_d_oe_o <= lat_we ? {s_hi, s_lo} : 2'h0;
        ext_d_o <= {lat_wdata[s_hi_idx*8 +: 8],
                    lat_wdata[s_lo_idx*8 +: 8]};
      end
      ST_STRB:
        if (wdone) begin
          ext_cs_n_o <= 4'hf;
          ext_rd_n_o <= 1'b1;
          ext_wrl_n_o <= 1'b1;
          ext_wrh_n_o <= 1'b1;
          ext_d_oe_o <= 2'h0;
          cur_addr <= cur_addr + {22'h000000, cyc_n};
          idx <= idx + cyc_n;
          rem <= rem - {1'b0, cyc_n};
          if (rem == {1'b0, cyc_n})
            cpu_ack_o <= 1'b1;
        end
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Read assembly: only lanes that carry an operand byte are taken

genvar b;
generate
  for (b = 0; b < 4; b = b + 1) begin : g_rbyte
    always @(posedge clk_i) begin
      if (rst_i)
        cpu_rdata_o[b*8 +: 8] <= 8'h00;
      else if (state == ST_IDLE && cpu_req_i)
        cpu_rdata_o[b*8 +: 8] <= 8'h00;
      else if (state == ST_STRB && wdone && !lat_we) begin
        if (lo_use && lo_idx == b)
          cpu_rdata_o[b*8 +: 8] <= ext_d_i[7:0];
        else if (hi_use && hi_idx == b)
          cpu_rdata_o[b*8 +: 8] <= ext_d_i[15:8];
      end
    end
  end
endgenerate

csw_wait u_wait (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .start_i(start),
  .code_i(lat_code),
  .wait_n_i(wait_lvl),
  .done_o(wdone)
);
endmodule // csw_ctrl
`default_nettype wire

// ==== verilog/csw_wait.v ====
`default_nettype none
module csw_wait (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [2:0] code_i,
  input wire wait_n_i,
  output wire done_o
);
`include "csw_map.vh"

reg active;
reg adapt;
reg [3:0] cnt;
reg [3:0] load;

always @* begin
  case (code_i)
    `CSW_WC_2: load = `CSW_WN_2;
    `CSW_WC_1: load = `CSW_WN_1;
    `CSW_WC_1N: load = `CSW_WN_1;
    `CSW_WC_0: load = `CSW_WN_0;
    `CSW_WC_3: load = `CSW_WN_3;
    `CSW_WC_4: load = `CSW_WN_4;
    `CSW_WC_8: load = `CSW_WN_8;
    // Reserved code falls back to the reset policy
    default: load = `CSW_WN_2;
  endcase
end

// Pin only matters once the fixed wait has run out
assign done_o = active && (cnt == 4'h0) && !(adapt && !wait_n_i);

always @(posedge clk_i) begin
  if (rst_i) begin
    active <= 1'b0;
    adapt <= 1'b0;
    cnt <= 4'h0;
  end else if (start_i) begin
    active <= 1'b1;
    adapt <= (code_i == `CSW_WC_1N);
    cnt <= load;
  end else if (done_o) begin
    active <= 1'b0;
  end else if (active && cnt != 4'h0) begin
    cnt <= cnt - 4'h1;
  end
end
endmodule // csw_wait
`default_nettype wire
